// ---- common/cspr_pkg.sv ----
// Package with constants and types for the stack pointer, program counter and condition codes
// How it works
// RL1: Reset loads the stack pointer with 0x00ff.
// RL2: Stack pointer is a full 16-bit register pointing at the next free slot.
// RL3: Calls push the return address; interrupts push it plus CPU registers.
// RL4: Add-immediate-to-stack sign-extends the 8-bit operand onto the full pointer.
// RL5: Reset-stack-low-byte changes only the low byte of the pointer.
// RL6: Program counter increments on every instruction or operand byte fetch.
// RL7: Jump, branch, interrupt and return load a target instead.
// RL8: Reset loads the program counter from the vector at 0xfffe and 0xffff.
// RL9: Condition code bits 6 and 5 always read as one.
// RL10: Bit 7 is set on two's complement overflow, else cleared.
// RL11: Signed branches greater, greater-equal, less-equal, less use the overflow flag.
// RL12: Bit 4 is set on add carry from bit 3 into bit 4.
// RL13: Decimal adjust uses half-carry and carry to correct a BCD sum.
// RL14: Interrupt mask set blocks maskable interrupts; clear accepts them.
// RL15: Interrupt entry sets the mask after stacking, before the service routine.
// RL16: No interrupt is recognised at the boundary right after a mask clear.
// RL17: Bit 2 is set when the value's most significant bit is one.
// RL18: Bit 1 is set when the 8 or 16 bit value is all zeros.
// RL19: Bit 0 is set on carry out of bit 7 or borrow on subtraction.
// RL20: Vector byte at the lower address is the high byte.
// RL21: Bits 7..0 hold overflow, 1, 1, half-carry, mask, negative, zero, carry.
package cspr_pkg;
	localparam logic [15:0] CSPR_SP_RESET = 16'h00ff;
	localparam logic [15:0] CSPR_VEC_HI_ADDR = 16'hfffe;
	localparam logic [15:0] CSPR_VEC_LO_ADDR = 16'hffff;
	localparam logic [7:0] CSPR_LOW_BYTE_RESET = 8'hff;
	localparam int CSPR_BIT_V = 7;
	localparam int CSPR_BIT_ONE6 = 6;
	localparam int CSPR_BIT_ONE5 = 5;
	localparam int CSPR_BIT_H = 4;
	localparam int CSPR_BIT_I = 3;
	localparam int CSPR_BIT_N = 2;
	localparam int CSPR_BIT_Z = 1;
	localparam int CSPR_BIT_C = 0;
	localparam logic [7:0] CSPR_CCR_FIXED = 8'h60;
	localparam logic [7:0] CSPR_CCR_RESET = 8'h68;
	localparam logic [7:0] CSPR_DAA_LOW_FIX = 8'h06;
	localparam logic [7:0] CSPR_DAA_HIGH_FIX = 8'h60;
	localparam logic [3:0] CSPR_BCD_NIBBLE_MAX = 4'h9;
	localparam logic [7:0] CSPR_BCD_BYTE_MAX = 8'h99;
	localparam logic [15:0] CSPR_ONE16 = 16'h0001;

	// Stack-pointer operation codes
	typedef enum logic [2:0] {
		CSPR_SP_HOLD = 3'h0,
		CSPR_SP_PUSH = 3'h1,
		CSPR_SP_PULL = 3'h2,
		CSPR_SP_ADD_IMM = 3'h3,
		CSPR_SP_RESET_LOW = 3'h4,
		CSPR_SP_LOAD = 3'h5
	} cspr_sp_op_t;

	// Flag update codes driven by the execution unit
	typedef enum logic [2:0] {
		CSPR_CC_HOLD = 3'h0,
		CSPR_CC_ADD = 3'h1,
		CSPR_CC_SUB = 3'h2,
		CSPR_CC_LOGIC = 3'h3,
		CSPR_CC_DAA = 3'h4,
		CSPR_CC_LOAD = 3'h5
	} cspr_cc_op_t;

	// Signed branch conditions
	typedef enum logic [1:0] {
		CSPR_BR_GT = 2'h0,
		CSPR_BR_GE = 2'h1,
		CSPR_BR_LE = 2'h2,
		CSPR_BR_LT = 2'h3
	} cspr_br_t;

	// Reset vector fetch states
	typedef enum logic [3:0] {
		CSPR_ST_VEC_HI = 4'b0001,
		CSPR_ST_VEC_LO = 4'b0010,
		CSPR_ST_LOAD = 4'b0100,
		CSPR_ST_RUN = 4'b1000
	} cspr_state_t;
endpackage : cspr_pkg

// ---- rtl/cspr_regs.sv ----
// Stack pointer, program counter and condition code register of the core
`timescale 1ns/1ps
`default_nettype none
module cspr_regs (
	input wire logic mclk_i,
	input wire logic reset_i,
	// Reset vector fetch through the core's memory port
	output logic vec_rd_o,
	output logic [15:0] vec_addr_o,
	input wire logic [7:0] mem_rdata_i,
	output logic reset_done_o,
	// Program counter control
	input wire logic fetch_i,
	input wire logic pc_load_i,
	input wire logic [15:0] pc_target_i,
	input wire logic branch_rel_i,
	input wire logic [7:0] branch_off_i,
	// Stack pointer control
	input wire cspr_pkg::cspr_sp_op_t sp_op_i,
	input wire logic [7:0] sp_imm_i,
	input wire logic [15:0] sp_load_i,
	// Condition codes from the ALU
	input wire cspr_pkg::cspr_cc_op_t cc_op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_in_i,
	input wire logic wide_i,
	input wire logic [15:0] value_i,
	input wire logic ccr_write_i,
	input wire logic [7:0] ccr_wdata_i,
	output logic [7:0] alu_result_o,
	// Interrupt control
	input wire logic mask_set_i,
	input wire logic mask_clear_i,
	input wire logic boundary_i,
	input wire logic irq_pending_i,
	output logic irq_take_o,
	input wire logic int_stacked_i,
	// Signed branch test
	input wire cspr_pkg::cspr_br_t br_cond_i,
	output logic br_true_o,
	// Register views
	output logic [15:0] stack_pointer_o,
	output logic [15:0] program_counter_o,
	output logic [7:0] condition_code_register_o
);
	import cspr_pkg::*;

	cspr_state_t state_r;
	logic [7:0] vec_hi_r;
	logic [15:0] stack_pointer_r;
	logic [15:0] program_counter_r;
	logic flag_v_r;
	logic flag_h_r;
	logic flag_i_r;
	logic flag_n_r;
	logic flag_z_r;
	logic flag_c_r;
	logic inhibit_r;
	logic [7:0] alu_result_r;
	logic [8:0] sum_nxt;
	logic [4:0] half_nxt;
	logic [7:0] daa_fix_nxt;
	logic [8:0] daa_sum_nxt;

	function automatic logic [15:0] sext8(input logic [7:0] b);
		sext8 = {{8{b[7]}}, b};
	endfunction : sext8

	// Reset vector fetch: high byte first from the lower address
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= CSPR_ST_VEC_HI;
			vec_hi_r <= 8'h00;
		end else begin
			case (state_r)
				CSPR_ST_VEC_HI: begin
					state_r <= CSPR_ST_VEC_LO;
				end
				CSPR_ST_VEC_LO: begin
					vec_hi_r <= mem_rdata_i; // RL20
					state_r <= CSPR_ST_LOAD;
				end
				CSPR_ST_LOAD: begin
					state_r <= CSPR_ST_RUN;
				end
				CSPR_ST_RUN: begin
					state_r <= CSPR_ST_RUN;
				end
				default: begin
					state_r <= CSPR_ST_VEC_HI;
				end
			endcase
		end
	end

	assign vec_rd_o = (state_r == CSPR_ST_VEC_HI) ||
		(state_r == CSPR_ST_VEC_LO);
	assign vec_addr_o = (state_r == CSPR_ST_VEC_LO) ?
		CSPR_VEC_LO_ADDR : CSPR_VEC_HI_ADDR;
	assign reset_done_o = (state_r == CSPR_ST_RUN);

	// Program counter
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			program_counter_r <= 16'h0000;
		end else if (state_r == CSPR_ST_LOAD) begin
			program_counter_r <= {vec_hi_r, mem_rdata_i}; // RL8 RL20
		end else if (state_r == CSPR_ST_RUN) begin
			if (pc_load_i) begin
				program_counter_r <= pc_target_i; // RL7
			end else if (branch_rel_i) begin
				program_counter_r <= program_counter_r +
					sext8(branch_off_i); // RL7
			end else if (fetch_i) begin
				program_counter_r <= program_counter_r + CSPR_ONE16; // RL6
			end
		end
	end

	// Stack pointer; the core's stacking sequence issues one push per byte
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			stack_pointer_r <= CSPR_SP_RESET; // RL1
		end else if (state_r == CSPR_ST_RUN) begin
			case (sp_op_i)
				CSPR_SP_PUSH: begin
					stack_pointer_r <= stack_pointer_r - CSPR_ONE16; // RL2 RL3
				end
				CSPR_SP_PULL: begin
					stack_pointer_r <= stack_pointer_r + CSPR_ONE16; // RL2
				end
				CSPR_SP_ADD_IMM: begin
					stack_pointer_r <= stack_pointer_r + sext8(sp_imm_i); // RL4
				end
				CSPR_SP_RESET_LOW: begin
					stack_pointer_r[7:0] <= CSPR_LOW_BYTE_RESET; // RL5
				end
				CSPR_SP_LOAD: begin
					stack_pointer_r <= sp_load_i; // RL2
				end
				default: begin
					stack_pointer_r <= stack_pointer_r;
				end
			endcase
		end
	end

	// ALU arithmetic feeding the flags
	always_comb begin
		sum_nxt = 9'h000;
		half_nxt = 5'h00;
		if (cc_op_i == CSPR_CC_SUB) begin
			sum_nxt = {1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_in_i};
		end else begin
			sum_nxt = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_in_i};
			half_nxt = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} +
				{4'h0, carry_in_i};
		end
	end

	// Decimal adjust correction from H, C and the accumulator value
	always_comb begin
		daa_fix_nxt = 8'h00;
		if (flag_h_r || (a_i[3:0] > CSPR_BCD_NIBBLE_MAX)) begin
			daa_fix_nxt = daa_fix_nxt | CSPR_DAA_LOW_FIX; // RL13
		end
		if (flag_c_r || (a_i > CSPR_BCD_BYTE_MAX)) begin
			daa_fix_nxt = daa_fix_nxt | CSPR_DAA_HIGH_FIX; // RL13
		end
		daa_sum_nxt = {1'b0, a_i} + {1'b0, daa_fix_nxt};
	end

	// Result register for the ALU output
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			alu_result_r <= 8'h00;
		end else begin
			case (cc_op_i)
				CSPR_CC_ADD, CSPR_CC_SUB: begin
					alu_result_r <= sum_nxt[7:0];
				end
				CSPR_CC_DAA: begin
					alu_result_r <= daa_sum_nxt[7:0];
				end
				default: begin
					alu_result_r <= alu_result_r;
				end
			endcase
		end
	end

	// Arithmetic flags V, H, N, Z, C
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_v_r <= 1'b0;
			flag_h_r <= 1'b0;
			flag_n_r <= 1'b0;
			flag_z_r <= 1'b0;
			flag_c_r <= 1'b0;
		end else if (ccr_write_i) begin
			flag_v_r <= ccr_wdata_i[CSPR_BIT_V];
			flag_h_r <= ccr_wdata_i[CSPR_BIT_H];
			flag_n_r <= ccr_wdata_i[CSPR_BIT_N];
			flag_z_r <= ccr_wdata_i[CSPR_BIT_Z];
			flag_c_r <= ccr_wdata_i[CSPR_BIT_C];
		end else begin
			case (cc_op_i)
				CSPR_CC_ADD: begin
					flag_v_r <= (a_i[7] == b_i[7]) &&
						(sum_nxt[7] != a_i[7]); // RL10
					flag_h_r <= half_nxt[4]; // RL12
					flag_n_r <= sum_nxt[7]; // RL17
					flag_z_r <= (sum_nxt[7:0] == 8'h00); // RL18
					flag_c_r <= sum_nxt[8]; // RL19
				end
				CSPR_CC_SUB: begin
					flag_v_r <= (a_i[7] != b_i[7]) &&
						(sum_nxt[7] != a_i[7]); // RL10
					flag_n_r <= sum_nxt[7]; // RL17
					flag_z_r <= (sum_nxt[7:0] == 8'h00); // RL18
					flag_c_r <= sum_nxt[8]; // RL19
				end
				CSPR_CC_DAA: begin
					flag_n_r <= daa_sum_nxt[7]; // RL17
					flag_z_r <= (daa_sum_nxt[7:0] == 8'h00); // RL18
					flag_c_r <= flag_c_r || daa_sum_nxt[8]; // RL13
				end
				CSPR_CC_LOGIC, CSPR_CC_LOAD: begin
					flag_v_r <= 1'b0;
					flag_n_r <= wide_i ? value_i[15] : value_i[7]; // RL17
					flag_z_r <= wide_i ? (value_i == 16'h0000) :
						(value_i[7:0] == 8'h00); // RL18
				end
				default: begin
					flag_v_r <= flag_v_r;
				end
			endcase
		end
	end

	// Interrupt mask; set by mask_set_i or once stacking is done
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_i_r <= CSPR_CCR_RESET[CSPR_BIT_I];
		end else if (int_stacked_i || mask_set_i) begin
			flag_i_r <= 1'b1; // RL15
		end else if (mask_clear_i) begin
			flag_i_r <= 1'b0;
		end else if (ccr_write_i) begin
			flag_i_r <= ccr_wdata_i[CSPR_BIT_I];
		end
	end

	// Hold off recognition for one boundary after the mask is cleared
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			inhibit_r <= 1'b0;
		end else if (mask_clear_i ||
			(ccr_write_i && !ccr_wdata_i[CSPR_BIT_I] && flag_i_r)) begin
			inhibit_r <= 1'b1; // RL16
		end else if (boundary_i) begin
			inhibit_r <= 1'b0; // RL16
		end
	end

	assign irq_take_o = irq_pending_i && boundary_i && !flag_i_r &&
		!inhibit_r && reset_done_o; // RL14 RL16

	// Signed branch conditions use N xor V
	always_comb begin
		case (br_cond_i)
			CSPR_BR_GT: br_true_o = !(flag_z_r || (flag_n_r ^ flag_v_r)); // RL11
			CSPR_BR_GE: br_true_o = !(flag_n_r ^ flag_v_r); // RL11
			CSPR_BR_LE: br_true_o = flag_z_r || (flag_n_r ^ flag_v_r); // RL11
			CSPR_BR_LT: br_true_o = flag_n_r ^ flag_v_r; // RL11
			default: br_true_o = 1'b0;
		endcase
	end

	assign alu_result_o = alu_result_r;
	assign stack_pointer_o = stack_pointer_r;
	assign program_counter_o = program_counter_r;
	// Bits 6 and 5 are not stored, so no write can change them
	assign condition_code_register_o = CSPR_CCR_FIXED |
		{flag_v_r, 2'b00, flag_h_r, flag_i_r,
		flag_n_r, flag_z_r, flag_c_r}; // RL9 RL21
endmodule : cspr_regs
`default_nettype wire

// ---- tb/cspr_regs_properties.sv ----
// Port-level checks for the sp, pc and condition code block
`timescale 1ns/1ps
`default_nettype none
module cspr_regs_checker
	import cspr_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic reset_done_o,
	input wire logic vec_rd_o,
	input wire logic [15:0] vec_addr_o,
	input wire logic fetch_i,
	input wire logic pc_load_i,
	input wire logic [15:0] pc_target_i,
	input wire logic branch_rel_i,
	input wire cspr_pkg::cspr_sp_op_t sp_op_i,
	input wire logic [7:0] sp_imm_i,
	input wire logic mask_set_i,
	input wire logic mask_clear_i,
	input wire logic int_stacked_i,
	input wire logic irq_take_o,
	input wire logic [15:0] stack_pointer_o,
	input wire logic [15:0] program_counter_o,
	input wire logic [7:0] condition_code_register_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);
	sp_reset_a: assert property ($fell(reset_i) |->
		stack_pointer_o == 16'h00ff)
		else $error("stack pointer wrong after reset");
	vec_order_a: assert property ($fell(reset_i) |->
		vec_rd_o && vec_addr_o == 16'hfffe ##1
		vec_rd_o && vec_addr_o == 16'hffff ##1
		!vec_rd_o ##1 reset_done_o)
		else $error("vector fetch order wrong");
	ones_fixed_a: assert property (
		condition_code_register_o[6:5] == 2'b11)
		else $error("fixed condition bits not one");
	pc_step_a: assert property (reset_done_o && fetch_i &&
		!pc_load_i && !branch_rel_i |=>
		program_counter_o == $past(program_counter_o) + 16'h0001)
		else $error("program counter did not step");
	pc_jump_a: assert property (reset_done_o && pc_load_i |=>
		program_counter_o == $past(pc_target_i))
		else $error("program counter missed target");
	sp_addimm_a: assert property (
		reset_done_o && sp_op_i == CSPR_SP_ADD_IMM |=>
		stack_pointer_o == $past(stack_pointer_o) +
		16'($signed($past(sp_imm_i))))
		else $error("stack add wrong");
	sp_lowbyte_a: assert property (
		reset_done_o && sp_op_i == CSPR_SP_RESET_LOW |=>
		$stable(stack_pointer_o[15:8]) && stack_pointer_o[7:0] == 8'hff)
		else $error("stack low byte reset wrong");
	mask_blocks_a: assert property (
		condition_code_register_o[3] |-> !irq_take_o)
		else $error("interrupt taken while masked");
	stack_mask_a: assert property (int_stacked_i |=>
		condition_code_register_o[3])
		else $error("mask not set after stacking");
	clear_inhibit_a: assert property (reset_done_o && mask_clear_i &&
		!mask_set_i && !int_stacked_i |=> !irq_take_o)
		else $error("interrupt taken right after mask clear");
endmodule : cspr_regs_checker
bind cspr_regs cspr_regs_checker u_chk (.mclk_i, .reset_i, .reset_done_o,
	.vec_rd_o, .vec_addr_o,
	.fetch_i, .pc_load_i, .pc_target_i, .branch_rel_i, .sp_op_i, .sp_imm_i,
	.mask_set_i, .mask_clear_i, .int_stacked_i, .irq_take_o, .stack_pointer_o,
	.program_counter_o, .condition_code_register_o);
`default_nettype wire

// ---- tb/cspr_regs_bench.sv ----
// Self-checking bench for the sp, pc and condition code block
`timescale 1ns/1ps
`default_nettype none
module cspr_regs_bench;
	import cspr_pkg::*;
	logic mclk_i = 0, reset_i = 1, fetch_i = 0, pc_load_i = 0, branch_rel_i = 0;
	logic carry_in_i = 0, wide_i = 0, ccr_write_i = 0, mask_set_i = 0;
	logic mask_clear_i = 0, boundary_i = 0, irq_pending_i = 0, int_stacked_i = 0;
	logic [7:0] mem_rdata_i = '0, branch_off_i = '0, sp_imm_i = '0;
	logic [7:0] a_i = '0, b_i = '0, ccr_wdata_i = '0;
	logic [15:0] pc_target_i = '0, sp_load_i = '0, value_i = '0;
	logic [7:0] alu_result_o, condition_code_register_o;
	logic [15:0] vec_addr_o, stack_pointer_o, program_counter_o;
	logic vec_rd_o, reset_done_o, irq_take_o, br_true_o;
	cspr_sp_op_t sp_op_i = CSPR_SP_HOLD;
	cspr_cc_op_t cc_op_i = CSPR_CC_HOLD;
	cspr_br_t br_cond_i = CSPR_BR_GT;
	int miscompares = 0, checks = 0, ps, ss, cs;
	logic [7:0] a, b, e, m, vhi, vlo;
	logic [8:0] r, q;
	logic [15:0] pc, sp;
	logic ci, sub, wd, nv, bt;
	int dx, dy;

	cspr_regs u_dut (.mclk_i, .reset_i, .vec_rd_o, .vec_addr_o, .mem_rdata_i,
		.reset_done_o, .fetch_i, .pc_load_i, .pc_target_i, .branch_rel_i,
		.branch_off_i, .sp_op_i, .sp_imm_i, .sp_load_i, .cc_op_i, .a_i, .b_i,
		.carry_in_i, .wide_i, .value_i, .ccr_write_i, .ccr_wdata_i,
		.alu_result_o, .mask_set_i, .mask_clear_i, .boundary_i, .irq_pending_i,
		.irq_take_o, .int_stacked_i, .br_cond_i, .br_true_o, .stack_pointer_o,
		.program_counter_o, .condition_code_register_o);

	always #10 mclk_i = ~mclk_i;
	// Synchronous memory: data follows the address one cycle later
	always @(posedge mclk_i) mem_rdata_i <= vec_addr_o == 16'hfffe ? vhi : vlo;

	task automatic chk(input string n, input logic [15:0] s, e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Decimal sum of two BCD operands, worked out in plain integers
	function automatic logic [8:0] bcd_sum(input int x, y, c);
		int s;
		s = x + y + c;
		bcd_sum = {s >= 100, 4'((s % 100) / 10), 4'(s % 10)};
	endfunction : bcd_sum

	task automatic cyc;
		@(posedge mclk_i);
		{fetch_i, pc_load_i, branch_rel_i, ccr_write_i} <= '0;
		{mask_set_i, mask_clear_i, boundary_i, int_stacked_i} <= '0;
		sp_op_i <= CSPR_SP_HOLD;
		cc_op_i <= CSPR_CC_HOLD;
		#1;
	endtask : cyc

	task automatic end_sim;
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	initial begin
		void'($urandom(32'h6faf));
		vhi = $urandom;
		vlo = $urandom;
		repeat (2) @(posedge mclk_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 8 && reset_done_o !== 1'b1; i++) cyc;
		if (reset_done_o !== 1'b1) begin
			miscompares++;
			end_sim;
		end
		pc = {vhi, vlo};
		sp = 16'h00ff;
		chk("pc", program_counter_o, pc);
		chk("sp", stack_pointer_o, sp);
		chk("vec_rd", vec_rd_o, 1'b0);
		for (int k = 0; k < 300; k++) begin
			@(posedge mclk_i);
			a = $urandom;
			b = $urandom;
			ci = $urandom;
			wd = $urandom;
			cs = $urandom_range(2);
			ps = $urandom_range(3);
			ss = $urandom_range(5);
			sub = cs == 1;
			a_i <= a;
			b_i <= b;
			carry_in_i <= ci;
			wide_i <= wd;
			value_i <= {a, b};
			cc_op_i <= cs == 0 ? CSPR_CC_ADD : sub ? CSPR_CC_SUB :
				k[2] ? CSPR_CC_LOGIC : CSPR_CC_LOAD;
			br_cond_i <= cspr_br_t'(k[1:0]);
			fetch_i <= ps == 0 || ps == 3;
			pc_load_i <= ps[0];
			branch_rel_i <= ps == 2;
			pc_target_i <= {b, a};
			branch_off_i <= a;
			sp_imm_i <= b;
			sp_load_i <= {a, b};
			sp_op_i <= cspr_sp_op_t'(ss[2:0]);
			cyc;
			pc = ps[0] ? {b, a} : ps == 2 ? pc + {{8{a[7]}}, a} : pc + 16'h0001;
			case (ss)
				1: sp = sp - 16'h0001;
				2: sp = sp + 16'h0001;
				3: sp = sp + {{8{b[7]}}, b};
				4: sp[7:0] = 8'hff;
				5: sp = {a, b};
				default: ;
			endcase
			chk("pc", program_counter_o, pc);
			chk("sp", stack_pointer_o, sp);
			r = sub ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + b + ci;
			if (cs == 2) begin
				e = {3'b011, 2'b00, wd ? a[7] : b[7],
					wd ? {a, b} == 16'h0000 : b == 8'h00, 1'b0};
				m = 8'he6;
			end else begin
				e = {((a[7] ^ b[7]) == sub) && (r[7] != a[7]), 2'b11,
					({1'b0, a[3:0]} + b[3:0] + ci) > 5'h0f, 1'b0, r[7],
					r[7:0] == 8'h00, r[8]};
				m = sub ? 8'he7 : 8'hf7;
				chk("alu", alu_result_o, r[7:0]);
			end
			chk("ccr", condition_code_register_o & m, e & m);
			nv = e[2] ^ e[7];
			case (k[1:0])
				0: bt = !(e[1] | nv);
				1: bt = !nv;
				2: bt = e[1] | nv;
				default: bt = nv;
			endcase
			chk("branch", br_true_o, bt);
		end
		// Binary add of BCD operands, then decimal adjust of that sum
		for (int k = 0; k < 20; k++) begin
			@(posedge mclk_i);
			dx = $urandom_range(99);
			dy = $urandom_range(99);
			ci = $urandom;
			a = 8'((dx / 10) * 16 + dx % 10);
			b = 8'((dy / 10) * 16 + dy % 10);
			a_i <= a;
			b_i <= b;
			carry_in_i <= ci;
			cc_op_i <= CSPR_CC_ADD;
			cyc;
			r = {1'b0, a} + b + ci;
			@(posedge mclk_i);
			a_i <= r[7:0];
			cc_op_i <= CSPR_CC_DAA;
			cyc;
			q = bcd_sum(dx, dy, ci);
			chk("daa", alu_result_o, q[7:0]);
			chk("daa_flags", condition_code_register_o[2:0],
				{q[7], q[7:0] == 8'h00, q[8]});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge mclk_i);
			ccr_write_i <= 1'b1;
			ccr_wdata_i <= k ? 8'hff : 8'h00;
			cyc;
			chk("ccr", condition_code_register_o, k ? 8'hff : 8'h60);
		end
		@(posedge mclk_i);
		mask_clear_i <= 1'b1;
		irq_pending_i <= 1'b1;
		cyc;
		@(posedge mclk_i);
		boundary_i <= 1'b1;
		#1 chk("take", irq_take_o, 1'b0);
		cyc;
		@(posedge mclk_i);
		boundary_i <= 1'b1;
		#1 chk("take", irq_take_o, 1'b1);
		cyc;
		@(posedge mclk_i);
		int_stacked_i <= 1'b1;
		cyc;
		chk("mask", condition_code_register_o[3], 1'b1);
		@(posedge mclk_i);
		boundary_i <= 1'b1;
		#1 chk("take", irq_take_o, 1'b0);
		cyc;
		// Clearing the mask by a register write also holds off one boundary
		@(posedge mclk_i);
		ccr_write_i <= 1'b1;
		ccr_wdata_i <= 8'h00;
		cyc;
		@(posedge mclk_i);
		boundary_i <= 1'b1;
		#1 chk("take", irq_take_o, 1'b0);
		cyc;
		@(posedge mclk_i);
		boundary_i <= 1'b1;
		#1 chk("take", irq_take_o, 1'b1);
		cyc;
		@(posedge mclk_i);
		mask_set_i <= 1'b1;
		cyc;
		chk("mask", condition_code_register_o[3], 1'b1);
		@(posedge mclk_i);
		boundary_i <= 1'b1;
		#1 chk("take", irq_take_o, 1'b0);
		cyc;
		end_sim;
	end
endmodule : cspr_regs_bench
`default_nettype wire
